// file: smfhl_regs.svh
// constants for the scan mux storage cell with output freeze
`ifndef SMFHL_REGS_SVH
`define SMFHL_REGS_SVH

// positions of each pin in the synchronised pin vector
`define SMFHL_PIN_NCLK    0
`define SMFHL_PIN_ACLK    1
`define SMFHL_PIN_CSEL    2
`define SMFHL_PIN_NDATA   3
`define SMFHL_PIN_ADATA   4
`define SMFHL_PIN_DSEL    5
`define SMFHL_PIN_FREEZE  6
`define SMFHL_PIN_COUNT   7

// reset values, and the release pipe value that ends a clear
`define SMFHL_RST_SYNC    7'h00
`define SMFHL_RST_TRUE    1'h0
`define SMFHL_RST_INV     1'h1
`define SMFHL_RST_BYPASS  1'h0
`define SMFHL_RST_REL     2'h0
`define SMFHL_REL_DONE    2'h3

`endif

// file: smfhl_pkg.sv
// types shared by the scan mux storage cell modules
package smfhl_pkg;

  // which of the two paths a select pin points at
  typedef enum logic {
    SMFHL_SRC_NORMAL,
    SMFHL_SRC_ALTERNATE
  } smfhl_src_t;

endpackage

// file: smfhl_sync_if.sv
// carrier for synchronised pin levels and their rising edges
`timescale 1ns/1ps
`default_nettype none
`include "smfhl_regs.svh"

interface smfhl_sync_if;
  logic [`SMFHL_PIN_COUNT-1:0] level; // filtered pin levels
  logic [`SMFHL_PIN_COUNT-1:0] rise;  // one-cycle rising edge marks

  modport source (output level, output rise);
  modport sink   (input level, input rise);
endinterface

`default_nettype wire

// file: smfhl_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge mark
`timescale 1ns/1ps
`default_nettype none
`include "smfhl_regs.svh"

module smfhl_pin_sync (
  input  wire logic                        clk,     // system clock
  input  wire logic                        reset_n, // async reset, low
  input  wire logic [`SMFHL_PIN_COUNT-1:0] raw,     // pins from outside
  smfhl_sync_if.source                     sync     // levels and edges
);

  logic [`SMFHL_PIN_COUNT-1:0] stage1;
  logic [`SMFHL_PIN_COUNT-1:0] stage2;
  logic [`SMFHL_PIN_COUNT-1:0] stage3;
  logic [`SMFHL_PIN_COUNT-1:0] level;
  logic [`SMFHL_PIN_COUNT-1:0] rise;
  wire  [`SMFHL_PIN_COUNT-1:0] agree;
  wire  [`SMFHL_PIN_COUNT-1:0] next_level;
  wire  [`SMFHL_PIN_COUNT-1:0] next_rise;

  // a change counts only once stage two and three agree
  assign agree      = ~(stage2 ^ stage3);
  assign next_level = (stage3 & agree) | (level & ~agree);
  assign next_rise  = next_level & ~level;

  // stage1 feeds only stage2, never any logic
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= `SMFHL_RST_SYNC;
      stage2 <= `SMFHL_RST_SYNC;
      stage3 <= `SMFHL_RST_SYNC;
    end
    else
    begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // filtered level and edge mark leave together
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      level <= `SMFHL_RST_SYNC;
      rise  <= `SMFHL_RST_SYNC;
    end
    else
    begin
      level <= next_level;
      rise  <= next_rise;
    end
  end

  assign sync.level = level;
  assign sync.rise  = rise;

endmodule // smfhl_pin_sync

`default_nettype wire

// file: smfhl_cell.sv
// scan mux storage cell with output freeze stage and bypass output
`timescale 1ns/1ps
`default_nettype none
`include "smfhl_regs.svh"

module smfhl_cell (
  input  wire logic clk,               // system clock, 100 MHz
  input  wire logic reset_n,           // system reset, async, low
  input  wire logic async_clear_n,     // cell clear pin, async, low
  input  wire logic normal_clock,      // normal capture clock pin
  input  wire logic alternate_clock,   // scan capture clock pin
  input  wire logic clock_select,      // high picks alternate clock
  input  wire logic normal_data_in,    // normal data pin
  input  wire logic alternate_data_in, // scan data pin
  input  wire logic data_select,       // high picks alternate data
  input  wire logic output_freeze,     // high holds true/inverted
  output var  logic true_output,       // held captured value
  output var  logic inverted_output,   // held inverse value
  output var  logic bypass_output      // captured value, never held
);

  // picks between normal and alternate by source select
  function automatic logic pick_source(
    input smfhl_pkg::smfhl_src_t src,
    input logic                  normal_val,
    input logic                  alternate_val
  );
    logic result;
    result = normal_val;
    case (src)
      smfhl_pkg::SMFHL_SRC_NORMAL:    result = normal_val;
      smfhl_pkg::SMFHL_SRC_ALTERNATE: result = alternate_val;
      default:                        result = normal_val;
    endcase
    return result;
  endfunction

  // all pins arrive from outside the clk domain
  smfhl_sync_if pins ();

  wire  [`SMFHL_PIN_COUNT-1:0] raw_pins;
  wire                         clear_all_n;
  logic [1:0]                  release_pipe;
  wire                         cell_rst_n;
  smfhl_pkg::smfhl_src_t       clock_src;
  smfhl_pkg::smfhl_src_t       data_src;
  wire                         capture_edge;
  wire                         capture_data;
  wire                         frozen;
  logic                        captured;
  wire                         next_captured;
  wire                         next_true;
  wire                         next_inverted;

  // pin vector in the order the constants give
  assign raw_pins[`SMFHL_PIN_NCLK]   = normal_clock;
  assign raw_pins[`SMFHL_PIN_ACLK]   = alternate_clock;
  assign raw_pins[`SMFHL_PIN_CSEL]   = clock_select;
  assign raw_pins[`SMFHL_PIN_NDATA]  = normal_data_in;
  assign raw_pins[`SMFHL_PIN_ADATA]  = alternate_data_in;
  assign raw_pins[`SMFHL_PIN_DSEL]   = data_select;
  assign raw_pins[`SMFHL_PIN_FREEZE] = output_freeze;

  // data and clocks share one latency, so setup order is kept
  smfhl_pin_sync u_pin_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .raw     (raw_pins),
    .sync    (pins.source)
  );

  // clear asserts at once, but releases on a clk edge to
  // avoid a capture racing the removal of the clear
  assign clear_all_n = reset_n & async_clear_n;

  always_ff @(posedge clk or negedge clear_all_n)
  begin
    if (!clear_all_n)
      release_pipe <= `SMFHL_RST_REL;
    else
      release_pipe <= {release_pipe[0], 1'b1};
  end

  assign cell_rst_n = clear_all_n & (release_pipe == `SMFHL_REL_DONE);

  // source selection for clock and data
  assign clock_src = smfhl_pkg::smfhl_src_t'(pins.level[`SMFHL_PIN_CSEL]);
  assign data_src  = smfhl_pkg::smfhl_src_t'(pins.level[`SMFHL_PIN_DSEL]);

  // only a rising edge of the chosen clock captures
  assign capture_edge = pick_source(clock_src,
                                    pins.rise[`SMFHL_PIN_NCLK],
                                    pins.rise[`SMFHL_PIN_ACLK]);

  // chosen data input, alternate when data_select is high
  assign capture_data = pick_source(data_src,
                                    pins.level[`SMFHL_PIN_NDATA],
                                    pins.level[`SMFHL_PIN_ADATA]);

  assign frozen = pins.level[`SMFHL_PIN_FREEZE];

  // storage keeps its value with no edge, however long
  assign next_captured = capture_edge ? capture_data : captured;

  // freeze stage: hold when frozen, else pass value and inverse
  assign next_true     = frozen ? true_output     : next_captured;
  assign next_inverted = frozen ? inverted_output : ~next_captured;

  // storage element; clear forces it low regardless of clocks
  always_ff @(posedge clk or negedge cell_rst_n)
  begin
    if (!cell_rst_n)
      captured <= `SMFHL_RST_BYPASS;
    else
      captured <= next_captured;
  end

  // bypass follows storage directly, freeze has no say here
  always_ff @(posedge clk or negedge cell_rst_n)
  begin
    if (!cell_rst_n)
      bypass_output <= `SMFHL_RST_BYPASS;
    else
      bypass_output <= next_captured;
  end

  // freeze stage registers; clear overrides freeze
  always_ff @(posedge clk or negedge cell_rst_n)
  begin
    if (!cell_rst_n)
    begin
      true_output     <= `SMFHL_RST_TRUE;
      inverted_output <= `SMFHL_RST_INV;
    end
    else
    begin
      true_output     <= next_true;
      inverted_output <= next_inverted;
    end
  end

endmodule // smfhl_cell

`default_nettype wire

// file: smfhl_cell_props.sv
// concurrent checks on the scan storage cell ports
`timescale 1ns/1ps
`default_nettype none
module smfhl_cell_props (
  input wire logic clk,               // clock
  input wire logic reset_n,           // reset
  input wire logic async_clear_n,     // clear
  input wire logic normal_clock,      // clock
  input wire logic alternate_clock,   // clock
  input wire logic clock_select,      // pick
  input wire logic normal_data_in,    // data
  input wire logic alternate_data_in, // data
  input wire logic data_select,       // pick
  input wire logic output_freeze,     // hold
  input wire logic true_output,       // out
  input wire logic inverted_output,   // out
  input wire logic bypass_output      // out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // data the cell should take on an edge
  wire logic sel_d = data_select ? alternate_data_in : normal_data_in;
  sequence s_nrise;
    !clock_select && !normal_clock ##1 !clock_select && normal_clock;
  endsequence
  sequence s_arise;
    clock_select && !alternate_clock ##1 clock_select && alternate_clock;
  endsequence
  // five edges covers the four to five edge pin latency
  property p_ncap; s_nrise |-> ##5 bypass_output == $past(sel_d, 5); endproperty
  property p_acap; s_arise |-> ##5 bypass_output == $past(sel_d, 5); endproperty
  property p_nidle;
    (!clock_select && !normal_clock)[*8] |=> $stable(bypass_output) || !async_clear_n;
  endproperty
  property p_aidle;
    (clock_select && !alternate_clock)[*8] |=> $stable(bypass_output) || !async_clear_n;
  endproperty
  property p_frz; output_freeze[*7] |=> $stable(true_output) || !async_clear_n; endproperty
  property p_pass; (!output_freeze)[*7] |-> true_output == bypass_output; endproperty
  property p_inv; true_output != inverted_output; endproperty
  // clear must show all three reset levels, not only the low ones
  property p_clr;
    !async_clear_n |-> !true_output && inverted_output && !bypass_output;
  endproperty
  a_ncap: assert property (p_ncap) else $error("normal capture wrong");
  a_acap: assert property (p_acap) else $error("scan capture wrong");
  a_nidle: assert property (p_nidle) else $error("change without edge");
  a_aidle: assert property (p_aidle) else $error("change without edge");
  a_frz: assert property (p_frz) else $error("frozen output moved");
  a_pass: assert property (p_pass) else $error("output not passed");
  a_inv: assert property (p_inv) else $error("outputs not inverse");
  a_clr: assert property (p_clr) else $error("clear not applied");
endmodule // smfhl_cell_props
bind smfhl_cell smfhl_cell_props chk_u (.clk(clk), .reset_n(reset_n),
  .async_clear_n(async_clear_n), .normal_clock(normal_clock),
  .alternate_clock(alternate_clock), .clock_select(clock_select),
  .normal_data_in(normal_data_in), .alternate_data_in(alternate_data_in),
  .data_select(data_select), .output_freeze(output_freeze), .true_output(true_output),
  .inverted_output(inverted_output), .bypass_output(bypass_output));
`default_nettype wire

// file: smfhl_ctrl.sv
// surrounding controller: picks a clock and makes one pulse on request
`timescale 1ns/1ps
`default_nettype none
module smfhl_ctrl (
  input  wire logic go,              // start pulse
  input  wire logic clk,             // clock
  input  wire logic reset_n,         // reset
  input  wire logic alt,             // scan path
  input  wire logic stray,           // pulse other clock
  output var  logic busy,            // pulse running
  output var  logic normal_clock,    // clock
  output var  logic alternate_clock, // clock
  output var  logic clock_select     // pick
);
  int   cnt;
  logic on;
  // select moves only at start, both clocks low then
  always @(posedge clk)
  begin
    if (!reset_n)
      {cnt, clock_select} <= '0;
    else if (cnt == 0 && go)
      {cnt, clock_select} <= {32'd1, alt};
    else if (cnt != 0)
      cnt <= (cnt == 20) ? 0 : cnt + 1;
  end
  // long high phase so the sampled edge is never missed; scan path
  assign on = cnt >= 6 && cnt < 12;
  assign alternate_clock = on && (clock_select ^ stray);
  assign normal_clock = on && !(clock_select ^ stray);
  assign busy = cnt != 0;
endmodule // smfhl_ctrl
`default_nettype wire

// file: smfhl_cell_bench.sv
// self-checking bench for the scan storage cell
`timescale 1ns/1ps
`default_nettype none
module smfhl_cell_bench;
  logic clk = 1'b0, reset_n = 1'b0, clr_n = 1'b1, go = 1'b0, alt = 1'b0, stray = 1'b0;
  logic nd = 1'b0, ad = 1'b0, dsel = 1'b0, frz = 1'b0;
  wire logic nclk, aclk, csel, busy, q, qn, qx;
  int n_mismatch = 0, tests_run = 0, cyc = 0, stored = 0, held = 0;
  always #5 clk = ~clk;
  smfhl_cell dut_u (.clk(clk), .reset_n(reset_n), .async_clear_n(clr_n),
    .normal_clock(nclk), .alternate_clock(aclk), .clock_select(csel), .normal_data_in(nd),
    .alternate_data_in(ad), .data_select(dsel), .output_freeze(frz), .true_output(q),
    .inverted_output(qn), .bypass_output(qx));
  smfhl_ctrl ctrl_u (.clk(clk), .reset_n(reset_n), .go(go), .alt(alt), .stray(stray),
    .busy(busy), .normal_clock(nclk), .alternate_clock(aclk), .clock_select(csel));
  task automatic close_out();
    $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // model outputs against the cell, just after the edge settles
  task automatic check_outs(input string what);
    #1;
    if (!frz) held = stored;
    tests_run++;
    if (q !== held[0] || qn !== !held[0] || qx !== stored[0])
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, what);
    end
    $display("test %s finished", what);
  endtask
  // one pulse; data stays put until the controller is idle again
  task automatic pulse(input logic a, input logic s);
    @(posedge clk) {alt, stray, go} <= {a, s, 1'b1};
    @(posedge clk) go <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy) @(posedge clk);
    if (!s) stored = dsel ? ad : nd;
  endtask
  // hang guard, far above the roughly nine hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    void'($urandom(54));
    repeat (3) @(posedge clk);
    check_outs("reset");
    repeat (13) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk) {nd, ad, dsel, frz} <= 4'($urandom);
      pulse(1'($urandom), 1'b0);
      check_outs("capture");
      pulse(1'($urandom), 1'b1);
      check_outs("stray");
    end
    @(posedge clk) {frz, dsel, nd} <= {2'b10, !stored[0]};
    pulse(1'b0, 1'b0);
    check_outs("frozen");
    repeat (60) @(posedge clk);
    check_outs("idle");
    @(posedge clk) clr_n <= 1'b0;
    {stored, held} = '0;
    check_outs("clear");
    @(posedge clk) {clr_n, frz} <= 2'b10;
    repeat (8) @(posedge clk);
    check_outs("release");
    // a capture after release proves the clear let go of the cell
    @(posedge clk) {dsel, nd} <= 2'b01;
    pulse(1'b0, 1'b0);
    check_outs("after clear");
    close_out();
  end
endmodule // smfhl_cell_bench
`default_nettype wire
